// [grp_sel_pkg.sv]
// constants and types shared by the parameter set selector files
// assumes a single system clock and a synchronous reset
package grp_sel_pkg;

  localparam int unsigned NUM_GROUPS = 8;
  localparam int unsigned IDX_W = 3;
  localparam int unsigned SEL_W = 4;

  typedef logic [IDX_W-1:0] grp_idx_t;
  typedef logic [SEL_W-1:0] grp_sel_t;
  typedef logic [NUM_GROUPS-1:0] grp_vec_t;

  // selection field codes: 0 none, 1..8 param_set_one..param_set_eight
  localparam grp_sel_t SEL_NONE = 4'h0;
  localparam grp_sel_t SEL_LAST = 4'h8;
  localparam grp_sel_t SEL_RST = 4'h0;
  localparam grp_sel_t SEL_STEP = 4'h1;

  // usable groups code: 0 only param_set_one .. 7 all eight
  localparam grp_idx_t USED_RST = 3'h0;
  localparam grp_idx_t ACTIVE_RST = 3'h0;
  localparam grp_vec_t ACT_RST = 8'h00;
  localparam grp_vec_t MASK_RST = 8'h01;
  localparam grp_vec_t VEC_ONE = 8'h01;

  function automatic grp_idx_t sel_to_idx(input grp_sel_t s);
    return grp_idx_t'(s - SEL_STEP);
  endfunction : sel_to_idx

  function automatic grp_vec_t idx_to_vec(input grp_idx_t i);
    return grp_vec_t'(VEC_ONE << i);
  endfunction : idx_to_vec

endpackage : grp_sel_pkg

// [grp_sel_if.sv]
// request and usable-range signals between the selector and its helpers
// assumes all parties sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface grp_sel_if;
  grp_sel_pkg::grp_vec_t req;
  grp_sel_pkg::grp_idx_t win;
  logic win_vld;
  grp_sel_pkg::grp_idx_t used_code;
  grp_sel_pkg::grp_vec_t used_mask;
  grp_sel_pkg::grp_vec_t newly_usable;

  modport main (output req, output used_code, input win, input win_vld,
                input used_mask, input newly_usable);
  modport enc (input req, output win, output win_vld);
  modport trk (input used_code, output used_mask, output newly_usable);
endinterface : grp_sel_if
`default_nettype wire

// [group_prio_enc.sv]
// fixed priority pick among requested parameter sets
// assumes requests already masked to the usable range
`timescale 1ns/1ps
`default_nettype none
module group_prio_enc (
  grp_sel_if.enc g
);
  grp_sel_pkg::grp_idx_t win_c;
  logic vld_c;

  // a held level blocks only lower groups
  always_comb begin
    win_c = grp_sel_pkg::ACTIVE_RST;
    vld_c = 1'b0;
    for (int i = int'(grp_sel_pkg::NUM_GROUPS) - 1; i >= 0; i--) begin
      if (g.req[i]) begin
        win_c = grp_sel_pkg::grp_idx_t'(i);
        vld_c = 1'b1;
      end
    end
  end

  assign g.win = win_c;
  assign g.win_vld = vld_c;
endmodule : group_prio_enc
`default_nettype wire

// [usable_tracker.sv]
// usable group mask and newly-usable pulses
// assumes the usable code comes from a register of the selector
`timescale 1ns/1ps
`default_nettype none
module usable_tracker (
  input wire logic mclk_i,
  input wire logic srst_i,
  grp_sel_if.trk g
);
  typedef struct packed {
    grp_sel_pkg::grp_vec_t mask;
    grp_sel_pkg::grp_vec_t load;
  } trk_state_t;

  trk_state_t q;
  trk_state_t d;
  grp_sel_pkg::grp_vec_t mask_c;

  for (genvar i = 0; i < grp_sel_pkg::NUM_GROUPS; i++) begin : g_mask
    assign mask_c[i] = (grp_sel_pkg::grp_idx_t'(i) <= g.used_code);
  end

  always_comb begin
    d = q;
    d.mask = mask_c;
    d.load = mask_c & ~q.mask;
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      q <= '{mask: grp_sel_pkg::MASK_RST, load: grp_sel_pkg::ACT_RST};
    end else begin
      q <= d;
    end
  end

  assign g.used_mask = mask_c;
  assign g.newly_usable = q.load;
endmodule : usable_tracker
`default_nettype wire

// [param_set_selector.sv]
// parameter set selector: picks the active one of eight parameter sets
// assumes inputs synchronous to mclk_i and single-cycle write strobes
`timescale 1ns/1ps
`default_nettype none
module param_set_selector (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [7:0] act_i,
  input wire logic override_enable_set_i,
  input wire logic override_enable_clr_i,
  input wire logic forced_wr_i,
  input wire logic [3:0] forced_sel_i,
  input wire logic remote_wr_i,
  input wire logic [3:0] remote_sel_i,
  input wire logic used_wr_i,
  input wire logic [2:0] used_i,
  output logic [2:0] active_idx_o,
  output logic forced_o,
  output logic override_enable_flag_o,
  output logic [3:0] forced_sel_o,
  output logic [3:0] remote_sel_o,
  output logic [2:0] used_o,
  output logic [7:0] load_defaults_o,
  output logic cfg_fail_o,
  output logic prio_fail_o,
  output logic force_fail_o
);

  typedef struct packed {
    grp_sel_pkg::grp_vec_t act_prev;
    logic en;
    grp_sel_pkg::grp_sel_t fsel;
    grp_sel_pkg::grp_sel_t rsel;
    grp_sel_pkg::grp_idx_t used;
    grp_sel_pkg::grp_idx_t active;
    logic forced;
    logic cfg_fail;
    logic prio_fail;
    logic force_fail;
  } sel_state_t;

  sel_state_t q;
  sel_state_t d;

  grp_sel_if g ();

  group_prio_enc u_enc (
    .g(g.enc)
  );

  usable_tracker u_trk (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .g(g.trk)
  );

  logic fsel_code_ok;
  logic rsel_code_ok;
  grp_sel_pkg::grp_idx_t fsel_idx;
  grp_sel_pkg::grp_idx_t rsel_idx;
  grp_sel_pkg::grp_vec_t rsel_vec;
  grp_sel_pkg::grp_vec_t rem_req;
  grp_sel_pkg::grp_vec_t rise;
  grp_sel_pkg::grp_vec_t held_above;

  assign fsel_code_ok = (forced_sel_i != grp_sel_pkg::SEL_NONE) &&
                        (forced_sel_i <= grp_sel_pkg::SEL_LAST);
  assign rsel_code_ok = (remote_sel_i != grp_sel_pkg::SEL_NONE) &&
                        (remote_sel_i <= grp_sel_pkg::SEL_LAST);
  assign fsel_idx = grp_sel_pkg::sel_to_idx(forced_sel_i);
  assign rsel_idx = grp_sel_pkg::sel_to_idx(remote_sel_i);
  assign rsel_vec = rsel_code_ok ? grp_sel_pkg::idx_to_vec(rsel_idx) : grp_sel_pkg::ACT_RST;
  // remote write is a one-shot request, dropped while forcing
  assign rem_req = (remote_wr_i && !q.en) ? rsel_vec : grp_sel_pkg::ACT_RST;
  // any input high is a request, pulse or level
  assign rise = act_i & ~q.act_prev;
  assign held_above = act_i & grp_sel_pkg::grp_vec_t'(rsel_vec - grp_sel_pkg::VEC_ONE);

  // remote and inputs meet in one priority pick
  // unusable groups never reach the pick
  assign g.req = (act_i | rem_req) & g.used_mask;
  assign g.used_code = q.used;

  always_comb begin
    d = q;
    d.cfg_fail = 1'b0;
    d.prio_fail = 1'b0;
    d.force_fail = 1'b0;
    d.act_prev = act_i;

    if (override_enable_set_i) begin
      d.en = 1'b1;
    end else if (override_enable_clr_i) begin
      d.en = 1'b0;
    end

    if (used_wr_i) begin
      d.used = used_i;
    end
    if (forced_wr_i) begin
      d.fsel = forced_sel_i;
    end
    if (remote_wr_i) begin
      d.rsel = remote_sel_i;
    end

    // a group dropped from the usable range cannot stay active
    if (q.active > q.used) begin
      d.active = grp_sel_pkg::ACTIVE_RST;
    end

    if (q.en) begin
      // forced pick only inside the usable range
      if (forced_wr_i && forced_sel_i != grp_sel_pkg::SEL_NONE) begin
        if (fsel_code_ok && fsel_idx <= q.used) begin
          d.active = fsel_idx;
          d.forced = 1'b1;
        end else begin
          d.cfg_fail = 1'b1;
        end
      end
      if (remote_wr_i && remote_sel_i != grp_sel_pkg::SEL_NONE) begin
        d.force_fail = 1'b1;
      end
    end else begin
      // force refused without the enable flag
      if (forced_wr_i && forced_sel_i != grp_sel_pkg::SEL_NONE) begin
        d.force_fail = 1'b1;
      end
      // held levels take over right after release
      // held group one always wins the pick
      // any request in the usable range, held level or pulse, moves the group
      if (g.win_vld) begin
        d.active = g.win;
        d.forced = 1'b0;
      end
      if (|(rise & ~g.used_mask)) begin
        d.cfg_fail = 1'b1;
      end
      if (remote_wr_i && remote_sel_i != grp_sel_pkg::SEL_NONE) begin
        if (~|(rsel_vec & g.used_mask)) begin
          d.cfg_fail = 1'b1;
        end else if (g.win < rsel_idx) begin
          d.prio_fail = 1'b1;
        end
      end
    end
    // otherwise active stays as it was
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      q <= '{act_prev: grp_sel_pkg::ACT_RST, en: 1'b0,
             fsel: grp_sel_pkg::SEL_RST, rsel: grp_sel_pkg::SEL_RST,
             used: grp_sel_pkg::USED_RST, active: grp_sel_pkg::ACTIVE_RST,
             forced: 1'b0, cfg_fail: 1'b0, prio_fail: 1'b0, force_fail: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign active_idx_o = q.active;
  assign forced_o = q.forced;
  assign override_enable_flag_o = q.en;
  assign forced_sel_o = q.fsel;
  assign remote_sel_o = q.rsel;
  assign used_o = q.used;
  assign load_defaults_o = g.newly_usable;
  assign cfg_fail_o = q.cfg_fail;
  assign prio_fail_o = q.prio_fail;
  assign force_fail_o = q.force_fail;

  // checks on the selection behaviour
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  property p_force_refused;
    forced_wr_i && fsel_code_ok && !q.en && !override_enable_set_i
      |=> force_fail_o && !$rose(forced_o);
  endproperty
  a_force_refused: assert property (p_force_refused)
    else $error("forced pick taken without enable flag");

  property p_force_taken;
    q.en && forced_wr_i && fsel_code_ok && (fsel_idx <= q.used) && !(q.active > q.used)
      |=> (active_idx_o == $past(fsel_idx)) && forced_o;
  endproperty
  a_force_taken: assert property (p_force_taken)
    else $error("enabled forced pick not applied");

  property p_release_levels;
    $fell(q.en) && act_i[0] |=> active_idx_o == grp_sel_pkg::ACTIVE_RST;
  endproperty
  a_release_levels: assert property (p_release_levels)
    else $error("held level did not retake control after release");

  property p_fields_reset;
    $past(srst_i) |-> (forced_sel_o == grp_sel_pkg::SEL_RST) &&
      (remote_sel_o == grp_sel_pkg::SEL_RST) && (used_o == grp_sel_pkg::USED_RST) &&
      (active_idx_o == grp_sel_pkg::ACTIVE_RST);
  endproperty
  a_fields_reset: assert property (p_fields_reset)
    else $error("field not at reset value after reset");

  property p_hold_last;
    !forced_wr_i && !remote_wr_i && (act_i == grp_sel_pkg::ACT_RST) &&
      !(q.active > q.used) |=> $stable(active_idx_o);
  endproperty
  a_hold_last: assert property (p_hold_last)
    else $error("active group moved with no request");

  property p_flag_sticky;
    q.en && !override_enable_clr_i ##1 !override_enable_clr_i [*2]
      |=> override_enable_flag_o [*1];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("enable flag dropped without a clear");

  property p_load_defaults;
    used_wr_i && (used_i == 3'h7) && (used_o == grp_sel_pkg::USED_RST)
      |=> ##1 load_defaults_o == 8'hFE;
  endproperty
  a_load_defaults: assert property (p_load_defaults)
    else $error("newly usable groups not loaded with defaults");

  property p_remote_blocked;
    !q.en && remote_wr_i && rsel_code_ok && (rsel_idx <= q.used) &&
      (|(held_above & g.used_mask)) |=> prio_fail_o && (active_idx_o != $past(rsel_idx));
  endproperty
  a_remote_blocked: assert property (p_remote_blocked)
    else $error("remote pick taken over a held higher group");

  property p_group_one_held;
    !q.en && act_i[0] [*2] |=> active_idx_o == grp_sel_pkg::ACTIVE_RST;
  endproperty
  a_group_one_held: assert property (p_group_one_held)
    else $error("held group one lost the selection");

  property p_highest_wins;
    !q.en && act_i[1] && act_i[2] && !act_i[0] && !remote_wr_i && (q.used >= 3'h2)
      |=> active_idx_o == 3'h1;
  endproperty
  a_highest_wins: assert property (p_highest_wins)
    else $error("lower group won over a higher simultaneous request");

  property p_out_of_range;
    !q.en && |(rise & ~g.used_mask) && ~|(act_i & g.used_mask) && !remote_wr_i &&
      !(q.active > q.used) |=> cfg_fail_o && $stable(active_idx_o);
  endproperty
  a_out_of_range: assert property (p_out_of_range)
    else $error("out-of-range request not flagged or not ignored");

  property p_flag_set;
    override_enable_set_i |=> override_enable_flag_o;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("enable flag not set by a set request");

  property p_flag_clear;
    override_enable_clr_i && !override_enable_set_i |=> !override_enable_flag_o;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("enable flag not cleared by a clear request");

  property p_force_range;
    q.en && forced_wr_i && (forced_sel_i != grp_sel_pkg::SEL_NONE) &&
      !(fsel_code_ok && (fsel_idx <= q.used)) && !(q.active > q.used)
      |=> cfg_fail_o && $stable(active_idx_o);
  endproperty
  a_force_range: assert property (p_force_range)
    else $error("forced pick outside the usable range not refused");

  property p_forced_hold;
    q.en && !forced_wr_i && !(q.active > q.used) |=> $stable(active_idx_o);
  endproperty
  a_forced_hold: assert property (p_forced_hold)
    else $error("active group moved while forcing without a forced pick");

  property p_remote_forced;
    q.en && remote_wr_i && (remote_sel_i != grp_sel_pkg::SEL_NONE) |=> force_fail_o;
  endproperty
  a_remote_forced: assert property (p_remote_forced)
    else $error("remote pick not refused while forcing");

  property p_forced_store;
    forced_wr_i |=> forced_sel_o == $past(forced_sel_i);
  endproperty
  a_forced_store: assert property (p_forced_store)
    else $error("forced field not stored");

  property p_remote_store;
    remote_wr_i |=> remote_sel_o == $past(remote_sel_i);
  endproperty
  a_remote_store: assert property (p_remote_store)
    else $error("remote field not stored");

  property p_used_store;
    used_wr_i |=> used_o == $past(used_i);
  endproperty
  a_used_store: assert property (p_used_store)
    else $error("usable code not stored");

  property p_group_one_wins;
    !q.en && act_i[0] |=> active_idx_o == grp_sel_pkg::ACTIVE_RST;
  endproperty
  a_group_one_wins: assert property (p_group_one_wins)
    else $error("group one request lost the pick");

  property p_eight_blocks_none;
    !q.en && act_i[7] && (act_i[6:0] == 7'h00) && remote_wr_i && rsel_code_ok &&
      (rsel_idx <= q.used) |=> !prio_fail_o && (active_idx_o == $past(rsel_idx));
  endproperty
  a_eight_blocks_none: assert property (p_eight_blocks_none)
    else $error("held last group blocked a remote pick");

  property p_active_in_range;
    q.active > q.used |=> active_idx_o <= $past(used_o);
  endproperty
  a_active_in_range: assert property (p_active_in_range)
    else $error("active group left outside the usable range");

  c_forced: cover property (q.en && forced_wr_i && fsel_code_ok ##1 forced_o);
  c_pulse_switch: cover property (!q.en && rise[3] ##1 act_i == grp_sel_pkg::ACT_RST [*3]);
  c_remote_ok: cover property (!q.en && remote_wr_i && rsel_code_ok ##1 !prio_fail_o);
  c_prio_fail: cover property (prio_fail_o);
  c_release: cover property ($fell(q.en) && |act_i);

endmodule : param_set_selector
`default_nettype wire

// [relay_far_side.sv]
// far side model: relay logic levels and pulses, link and panel writes
// assumes the bench calls its tasks; every drive change is at a falling edge
`timescale 1ns/1ps
`default_nettype none
module relay_far_side (
  input wire logic mclk_i,
  output logic [7:0] act_o,
  output logic en_set_o,
  output logic en_clr_o,
  output logic forced_wr_o,
  output logic [3:0] forced_sel_o,
  output logic remote_wr_o,
  output logic [3:0] remote_sel_o,
  output logic used_wr_o,
  output logic [2:0] used_o
);
  logic [7:0] lvl_q;
  initial begin
    lvl_q = 8'h00;
    act_o = 8'h00;
    {en_set_o, en_clr_o, forced_wr_o, remote_wr_o, used_wr_o} = 5'h00;
    {forced_sel_o, remote_sel_o, used_o} = 11'h000;
  end
  task automatic hold(input logic [7:0] v);
    @(negedge mclk_i);
    lvl_q = v;
    act_o = v;
  endtask : hold
  // one-cycle pulse on top of held levels
  task automatic pulse(input logic [7:0] v);
    @(negedge mclk_i);
    act_o = lvl_q | v;
    @(negedge mclk_i);
    act_o = lvl_q;
  endtask : pulse
  // k: 0 forced, 1 remote, 2 used, 3 flag set, 4 flag clear
  task automatic wr(input int k, input logic [3:0] v);
    @(negedge mclk_i);
    forced_wr_o = (k == 0);
    remote_wr_o = (k == 1);
    used_wr_o = (k == 2);
    en_set_o = (k == 3);
    en_clr_o = (k == 4);
    forced_sel_o = v;
    remote_sel_o = v;
    used_o = v[2:0];
    @(negedge mclk_i);
    {en_set_o, en_clr_o, forced_wr_o, remote_wr_o, used_wr_o} = 5'h00;
    // released fields flip so a stale value is never mistaken for data
    forced_sel_o = ~forced_sel_o;
    remote_sel_o = ~remote_sel_o;
    used_o = ~used_o;
  endtask : wr
endmodule : relay_far_side
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the parameter set selector
// assumes relay_far_side drives every selector input except clock and reset at falling edges
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk_i;
  logic srst_i;
  logic [7:0] act;
  logic en_set, en_clr, f_wr, r_wr, u_wr;
  logic [3:0] f_sel, r_sel, f_sel_q, r_sel_q;
  logic [2:0] used, used_q, active;
  logic forced, flag, cfg_fail, prio_fail, force_fail;
  logic [7:0] load;
  int mismatches;
  int checked;

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  relay_far_side u_far (.mclk_i(mclk_i), .act_o(act), .en_set_o(en_set),
    .en_clr_o(en_clr), .forced_wr_o(f_wr), .forced_sel_o(f_sel),
    .remote_wr_o(r_wr), .remote_sel_o(r_sel), .used_wr_o(u_wr), .used_o(used));

  param_set_selector u_dut (.mclk_i(mclk_i), .srst_i(srst_i), .act_i(act),
    .override_enable_set_i(en_set), .override_enable_clr_i(en_clr),
    .forced_wr_i(f_wr), .forced_sel_i(f_sel), .remote_wr_i(r_wr),
    .remote_sel_i(r_sel), .used_wr_i(u_wr), .used_i(used),
    .active_idx_o(active), .forced_o(forced), .override_enable_flag_o(flag),
    .forced_sel_o(f_sel_q), .remote_sel_o(r_sel_q), .used_o(used_q),
    .load_defaults_o(load), .cfg_fail_o(cfg_fail), .prio_fail_o(prio_fail),
    .force_fail_o(force_fail));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : step

  task automatic test_done;
    $display("TB: checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  // whole sequence is about a hundred and ten cycles
  initial begin
    #50000;
    mismatches++;
    test_done();
  end

  initial begin
    mismatches = 0;
    checked = 0;
    srst_i = 1'b1;
    step(20);
    srst_i = 1'b0;
    chk(8'(active), 8'h00);
    chk(8'(flag), 8'h00);
    chk(8'(f_sel_q), 8'h00);
    chk(8'(r_sel_q), 8'h00);
    chk(8'(used_q), 8'h00);
    chk(load, 8'h00);
    u_far.pulse(8'h08);
    chk(8'(cfg_fail), 8'h01);
    chk(8'(active), 8'h00);
    u_far.wr(2, 4'h7);
    chk(8'(used_q), 8'h07);
    step(1);
    chk(load, 8'hFE);
    step(1);
    chk(load, 8'h00);
    for (int i = 7; i >= 0; i--) begin
      u_far.pulse(8'h01 << i);
      chk(8'(active), 8'(i));
    end
    u_far.pulse(8'h08);
    step(5);
    chk(8'(active), 8'h03);
    u_far.pulse(8'h06);
    chk(8'(active), 8'h01);
    u_far.pulse(8'h24);
    chk(8'(active), 8'h02);
    u_far.hold(8'h80);
    step(1);
    u_far.wr(1, 4'h3);
    chk(8'(active), 8'h02);
    chk(8'(r_sel_q), 8'h03);
    u_far.hold(8'h02);
    step(1);
    chk(8'(active), 8'h01);
    u_far.wr(1, 4'h4);
    chk(8'(prio_fail), 8'h01);
    chk(8'(active), 8'h01);
    u_far.hold(8'h01);
    step(1);
    u_far.wr(1, 4'h2);
    chk(8'(prio_fail), 8'h01);
    u_far.pulse(8'h10);
    chk(8'(active), 8'h00);
    u_far.wr(0, 4'h5);
    chk(8'(force_fail), 8'h01);
    chk(8'(active), 8'h00);
    u_far.wr(3, 4'h0);
    chk(8'(flag), 8'h01);
    u_far.wr(0, 4'h5);
    chk(8'(active), 8'h04);
    chk(8'(forced), 8'h01);
    chk(8'(f_sel_q), 8'h05);
    step(4);
    chk(8'(active), 8'h04);
    u_far.wr(1, 4'h2);
    chk(8'(force_fail), 8'h01);
    chk(8'(active), 8'h04);
    u_far.wr(0, 4'h9);
    chk(8'(cfg_fail), 8'h01);
    u_far.wr(4, 4'h0);
    chk(8'(flag), 8'h00);
    step(1);
    chk(8'(active), 8'h00);
    u_far.hold(8'h00);
    u_far.wr(3, 4'h0);
    u_far.wr(0, 4'h6);
    u_far.wr(4, 4'h0);
    step(5);
    chk(8'(active), 8'h05);
    u_far.pulse(8'h04);
    chk(8'(active), 8'h02);
    u_far.pulse(8'h40);
    u_far.wr(2, 4'h1);
    step(1);
    chk(8'(active), 8'h00);
    chk(load, 8'h00);
    u_far.pulse(8'h02);
    chk(8'(active), 8'h01);
    // second reset in mid-run
    srst_i = 1'b1;
    step(2);
    srst_i = 1'b0;
    chk(8'(active), 8'h00);
    chk(8'(used_q), 8'h00);
    u_far.pulse(8'h02);
    chk(8'(cfg_fail), 8'h01);
    chk(8'(active), 8'h00);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
